// ### hw/kpsc_pkg.sv
package kpsc_pkg;

  // register offsets as seen by the serial register engine
  localparam logic [7:0] KPSC_CTRL_HIGH_ADDR = 8'h63;
  localparam logic [7:0] KPSC_CTRL_LOW_ADDR  = 8'h64;
  localparam logic [7:0] KPSC_REPORT0_ADDR   = 8'h68;
  localparam logic [7:0] KPSC_REPORT1_ADDR   = 8'h69;
  localparam logic [7:0] KPSC_REPORT2_ADDR   = 8'h6A;
  localparam logic [7:0] KPSC_SF_ADDR        = 8'h6B;
  localparam logic [7:0] KPSC_DED_ADDR       = 8'h6C;

  // reset values
  localparam logic [7:0] KPSC_CTRL_RST   = 8'h00;
  localparam logic [7:0] KPSC_REPORT_RST = 8'hF8;
  localparam logic [7:0] KPSC_SF_RST     = 8'hFF;
  localparam logic [3:0] KPSC_DED_RST    = 4'hF;

  // field positions
  localparam int KPSC_SCAN_BIT     = 0;
  localparam int KPSC_DEB_LSB      = 1;
  localparam int KPSC_DEB_MSB      = 7;
  localparam int KPSC_SCNT_LSB     = 4;
  localparam int KPSC_SCNT_MSB     = 7;
  localparam int KPSC_DKEY_MSB     = 3;
  localparam logic [3:0] KPSC_NO_KEY_ROW = 4'hF;

  // timing: debounce step is one millisecond at the 5 ns clock
  localparam int KPSC_CLK_PERIOD_NS    = 5;
  localparam int KPSC_DEB_STEP_MS      = 1;
  localparam int KPSC_DEB_STEP_CYC     = KPSC_DEB_STEP_MS * 1000000 / KPSC_CLK_PERIOD_NS;
  localparam int KPSC_ROW_SETTLE_CYC   = 16;
  localparam logic [3:0] KPSC_SF_PHASE = 4'h8;

  // scan sequencer states, gray along idle -> drive -> sample
  typedef enum logic [1:0] {
    KPSC_IDLE   = 2'b00,
    KPSC_DRIVE  = 2'b01,
    KPSC_SAMPLE = 2'b11
  } kpsc_scan_e;

  // report byte: released flag on top, then row, then column
  function automatic logic [7:0] kpsc_make_report(input logic       key_down,
                                                  input logic [3:0] row,
                                                  input logic [2:0] col);
    return {~key_down, row, col};
  endfunction

endpackage

// ### hw/kpsc_report_hold.sv
`timescale 1ns/1ps
module kpsc_report_hold
  import kpsc_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // report handshake with the scanner
  kpsc_report_if.holder rif
);

  logic [2:0][7:0] shown, next_shown;   // bytes visible to the host
  logic            pending, next_pending; // set not yet read
  logic            press, next_press;   // unread key-down in the set

  // a load in the same cycle as the read wins, so no event is lost
  always_comb
  begin
    next_shown   = shown;
    next_pending = pending;
    next_press   = press;
    if (rif.consume)
    begin
      next_pending = 1'b0;
      next_press   = 1'b0;
    end
    if (rif.load)
    begin
      next_shown   = rif.slots;
      next_pending = 1'b1;
      next_press   = rif.has_press;
    end
  end

  // registers only
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      shown   <= {3{KPSC_REPORT_RST}};
      pending <= 1'b0;
      press   <= 1'b0;
    end
    else
    begin
      shown   <= next_shown;
      pending <= next_pending;
      press   <= next_press;
    end
  end

  assign rif.shown = shown;
  assign rif.busy  = pending;
  assign rif.irq   = press;

  press_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
    rif.load && rif.has_press |=> rif.irq ##1 (rif.irq || $past(rif.consume)))
    else $error("interrupt not raised for unread key press");

  read_clears_a: assert property (@(posedge clk) disable iff (sys_rst)
    rif.consume && !rif.load |=> !rif.irq && !rif.busy)
    else $error("interrupt still set after report read");

endmodule

// ### hw/kpsc_report_if.sv
`timescale 1ns/1ps
interface kpsc_report_if;
  logic            load;       // new report set offered
  logic [2:0][7:0] slots;      // offered report bytes
  logic            has_press;  // offered set holds a key-down
  logic            consume;    // host has read the set
  logic            busy;       // held set still unread
  logic [2:0][7:0] shown;      // bytes the host reads
  logic            irq;        // unread key-down pending

  modport producer (output load, slots, has_press, consume,
                    input  busy, shown, irq);
  modport holder   (input  load, slots, has_press, consume,
                    output busy, shown, irq);
endinterface

// ### hw/kpsc_sync.sv
`timescale 1ns/1ps
module kpsc_sync
  import kpsc_pkg::*;
#(
  parameter int         W   = 8,
  parameter logic [7:0] RST = 8'hFF
)(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // pins and synchronised copy
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta;  // first stage, read only by the second

  // two-stage synchroniser, idles at released level
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      meta     <= RST[W-1:0];
      sync_out <= RST[W-1:0];
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// ### hw/kpsc_top.sv
// Functional notes
// - debounce time from control low bits 7:1
// - control low bit 0 starts/stops scanning
// - report byte: status, row, column fields
// - first report at 0x68, empty 0xF8
// - second report at 0x69, same layout
// - third report at 0x6A, same layout
// - dedicated keys in 0x6C bits 3:0
// - interrupt held while key press unread
// - results wait programmed scan count 0..15
// - dedicated enable turns column into key
`timescale 1ns/1ps
module kpsc_top
  import kpsc_pkg::*;
#(
  parameter int DEB_STEP_CYC   = KPSC_DEB_STEP_CYC,
  parameter int ROW_SETTLE_CYC = KPSC_ROW_SETTLE_CYC
)(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // register access from the serial engine
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // enables owned by other blocks
  input  wire logic       keypad_clock_enable,
  input  wire logic [7:0] row_enable,
  input  wire logic [7:0] col_enable,
  // keypad pins
  input  wire logic [7:0] col_in_n,
  output logic      [7:0] row_drive_n,
  // interrupt
  output logic            key_irq
);

  // row drive pattern for a scan phase; the spare phase drives none
  function automatic logic [7:0] row_select(input logic [3:0] ph, input logic [7:0] en);
    logic [7:0] sel;
    sel = 8'h00;
    if (ph != KPSC_SF_PHASE)
      sel = en & (8'h01 << ph[2:0]);
    return ~sel;
  endfunction

  kpsc_report_if rif ();

  logic [7:0]  ctrl_low, next_ctrl_low;     // debounce and scan bit
  logic [7:0]  ctrl_high, next_ctrl_high;   // scan count and dedicated enables
  logic [7:0]  next_rdata;                  // read data to register
  logic [7:0]  col_sync;                    // synchronised columns, low = contact
  kpsc_scan_e  scan_state, next_scan_state; // scan sequencer
  logic [3:0]  phase, next_phase;           // row phase 0..7, 8 = no row
  logic [15:0] settle, next_settle;         // settle counter per phase
  logic [7:0]  next_row_drive_n;            // row pins next value
  logic [63:0] acc_m, next_acc_m;           // matrix under collection
  logic        snap_done;                   // one full pass finished
  logic [63:0] snap_m;                      // matrix of the finished pass
  logic [7:0]  hits;                        // usable columns in contact
  logic [63:0] cand_m, next_cand_m;         // candidate matrix state
  logic [7:0]  cand_sf, next_cand_sf;       // candidate special keys
  logic [3:0]  cand_ded, next_cand_ded;     // candidate dedicated keys
  logic [31:0] ms_cnt, next_ms_cnt;         // cycles within a millisecond
  logic [6:0]  ms_el, next_ms_el;           // stable milliseconds
  logic [3:0]  scans, next_scans;           // stable scan passes
  logic        confirmed;                   // candidate is a confirmed result
  logic [63:0] reported, next_reported;     // keys reported as down
  logic [63:0] tmp_reported;                // reported view after this set
  logic [7:0]  sf_byte, next_sf_byte;       // special key byte, 1 = up
  logic [3:0]  ded_byte, next_ded_byte;     // dedicated key bits, 1 = up
  logic        scan_on;                     // scanning allowed
  logic [3:0]  ded_en;                      // columns used as dedicated keys

  assign scan_on = ctrl_low[KPSC_SCAN_BIT] & keypad_clock_enable;
  assign ded_en  = ctrl_high[KPSC_DKEY_MSB:0];

  kpsc_sync #(
    .W   (8),
    .RST (8'hFF)
  ) u_col_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (col_in_n),
    .sync_out (col_sync)
  );

  kpsc_report_hold u_hold (
    .clk     (clk),
    .sys_rst (sys_rst),
    .rif     (rif)
  );

  // dedicated columns leave the matrix
  assign hits = ~col_sync & col_enable & ~{4'h0, ded_en};

  // scan sequencer: drive a row, let it settle, sample the columns
  always_comb
  begin
    next_scan_state  = scan_state;
    next_phase       = phase;
    next_settle      = settle;
    next_acc_m       = acc_m;
    next_row_drive_n = 8'hFF;
    snap_done        = 1'b0;
    snap_m           = acc_m & ~{8{hits}};
    if (!scan_on)
    begin
      // stopping releases every row at once
      next_scan_state = KPSC_IDLE;
      next_phase      = 4'h0;
      next_settle     = 16'h0000;
    end
    else
    begin
      unique case (scan_state)
        KPSC_IDLE:
        begin
          next_scan_state = KPSC_DRIVE;
        end
        KPSC_DRIVE:
        begin
          next_row_drive_n = row_select(phase, row_enable);
          if (settle == 16'(ROW_SETTLE_CYC - 1))
          begin
            next_settle     = 16'h0000;
            next_scan_state = KPSC_SAMPLE;
          end
          else
            next_settle = settle + 16'h0001;
        end
        KPSC_SAMPLE:
        begin
          next_row_drive_n = row_select(phase, row_enable);
          next_scan_state  = KPSC_DRIVE;
          if (phase == KPSC_SF_PHASE)
          begin
            // a special key on a column hides matrix keys on it
            snap_done  = 1'b1;
            next_phase = 4'h0;
          end
          else
          begin
            next_acc_m[{phase[2:0], 3'b000} +: 8] = hits & {8{row_enable[phase[2:0]]}};
            next_phase = phase + 4'h1;
          end
        end
      endcase
    end
  end

  // debounce: a pass equal to the candidate extends its stable time
  always_comb
  begin
    next_cand_m   = cand_m;
    next_cand_sf  = cand_sf;
    next_cand_ded = cand_ded;
    next_ms_el    = ms_el;
    next_scans    = scans;
    if (ms_cnt == 32'(DEB_STEP_CYC - 1))
    begin
      next_ms_cnt = 32'h0000_0000;
      if (ms_el != 7'h7F)
        next_ms_el = ms_el + 7'h01;
    end
    else
      next_ms_cnt = ms_cnt + 32'h0000_0001;
    if (snap_done)
    begin
      if ({snap_m, hits, ~col_sync[3:0] & ded_en} != {cand_m, cand_sf, cand_ded})
      begin
        // any change restarts both the time and the pass count
        next_cand_m   = snap_m;
        next_cand_sf  = hits;
        next_cand_ded = ~col_sync[3:0] & ded_en;
        next_ms_cnt   = 32'h0000_0000;
        next_ms_el    = 7'h00;
        next_scans    = 4'h0;
      end
      else if (scans != 4'hF)
        next_scans = scans + 4'h1;
    end
  end

  assign confirmed = (ms_el >= ctrl_low[KPSC_DEB_MSB:KPSC_DEB_LSB]) &&
                     (scans >= ctrl_high[KPSC_SCNT_MSB:KPSC_SCNT_LSB]);

  // report builder: first three changes in row-major order form a set
  always_comb
  begin
    int n;
    int presses;
    n            = 0;
    presses      = $countones(reported);
    tmp_reported = reported;
    rif.slots    = {3{KPSC_REPORT_RST}};
    rif.has_press = 1'b0;
    if (confirmed)
    begin
      for (int k = 0; k < 64; k++)
      begin
        // at most three keys are reported as down at once
        if (n < 3 && cand_m[k] != reported[k] && !(cand_m[k] && presses >= 3))
        begin
          rif.slots[n] = kpsc_make_report(cand_m[k], {1'b0, 3'(k / 8)}, 3'(k));
          tmp_reported[k] = cand_m[k];
          if (cand_m[k])
          begin
            presses       = presses + 1;
            rif.has_press = 1'b1;
          end
          n = n + 1;
        end
      end
    end
    // a set is only offered once the previous one was read
    rif.load      = confirmed && (n != 0) && !rif.busy;
    next_reported = rif.load ? tmp_reported : reported;
    next_sf_byte  = confirmed ? ~cand_sf : sf_byte;
    next_ded_byte = confirmed ? ~cand_ded : ded_byte;
  end

  // register file: writes, read mux, read of the last report byte consumes
  always_comb
  begin
    next_ctrl_low  = ctrl_low;
    next_ctrl_high = ctrl_high;
    next_rdata     = reg_rdata;
    rif.consume    = reg_rd && (reg_addr == KPSC_REPORT2_ADDR);
    if (reg_wr && reg_addr == KPSC_CTRL_LOW_ADDR)
      next_ctrl_low = reg_wdata;
    if (reg_wr && reg_addr == KPSC_CTRL_HIGH_ADDR)
      next_ctrl_high = reg_wdata;
    if (reg_rd)
    begin
      unique case (reg_addr)
        KPSC_CTRL_HIGH_ADDR: next_rdata = ctrl_high;
        KPSC_CTRL_LOW_ADDR:  next_rdata = ctrl_low;
        KPSC_REPORT0_ADDR:   next_rdata = rif.shown[0];
        KPSC_REPORT1_ADDR:   next_rdata = rif.shown[1];
        KPSC_REPORT2_ADDR:   next_rdata = rif.shown[2];
        KPSC_SF_ADDR:        next_rdata = sf_byte;
        KPSC_DED_ADDR:       next_rdata = {4'h0, ded_byte};
        default:             next_rdata = 8'h00;             // unmapped reads zero
      endcase
    end
  end

  // all state registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl_low    <= KPSC_CTRL_RST;
      ctrl_high   <= KPSC_CTRL_RST;
      reg_rdata   <= 8'h00;
      scan_state  <= KPSC_IDLE;
      phase       <= 4'h0;
      settle      <= 16'h0000;
      row_drive_n <= 8'hFF;
      acc_m       <= 64'h0;
      cand_m      <= 64'h0;
      cand_sf     <= 8'h00;
      cand_ded    <= 4'h0;
      ms_cnt      <= 32'h0000_0000;
      ms_el       <= 7'h00;
      scans       <= 4'h0;
      reported    <= 64'h0;
      sf_byte     <= KPSC_SF_RST;
      ded_byte    <= KPSC_DED_RST;
      key_irq     <= 1'b0;
    end
    else
    begin
      ctrl_low    <= next_ctrl_low;
      ctrl_high   <= next_ctrl_high;
      reg_rdata   <= next_rdata;
      scan_state  <= next_scan_state;
      phase       <= next_phase;
      settle      <= next_settle;
      row_drive_n <= next_row_drive_n;
      acc_m       <= next_acc_m;
      cand_m      <= next_cand_m;
      cand_sf     <= next_cand_sf;
      cand_ded    <= next_cand_ded;
      ms_cnt      <= next_ms_cnt;
      ms_el       <= next_ms_el;
      scans       <= next_scans;
      reported    <= next_reported;
      sf_byte     <= next_sf_byte;
      ded_byte    <= next_ded_byte;
      key_irq     <= rif.irq;
    end
  end

  scan_stop_a: assert property (@(posedge clk) disable iff (sys_rst)
    !ctrl_low[KPSC_SCAN_BIT] |=> row_drive_n == 8'hFF)
    else $error("rows driven while scanning stopped");

  ctrl_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    reg_wr && reg_addr == KPSC_CTRL_LOW_ADDR |=> ctrl_low == $past(reg_wdata))
    else $error("control low write lost");

  report_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    reg_rd && reg_addr == KPSC_REPORT0_ADDR |=> reg_rdata == $past(rif.shown[0]))
    else $error("first report read wrong");

  reserved_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    reg_rd && reg_addr == KPSC_DED_ADDR |=> reg_rdata[7:4] == 4'h0)
    else $error("dedicated reserved bits not zero");

  scan_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    rif.load |-> scans >= ctrl_high[KPSC_SCNT_MSB:KPSC_SCNT_LSB])
    else $error("report loaded before scan count");

  debounce_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    rif.load |-> ms_el >= ctrl_low[KPSC_DEB_MSB:KPSC_DEB_LSB])
    else $error("report loaded before debounce time");

  ded_column_a: assert property (@(posedge clk) disable iff (sys_rst)
    rif.load && ctrl_high[0] |-> !(rif.slots[0][2:0] == 3'h0 &&
      rif.slots[0][6:3] != KPSC_NO_KEY_ROW))
    else $error("dedicated column reported as matrix key");

endmodule

// ### tb/kpsc_keypad_model.sv
`timescale 1ns/1ps
// key switch matrix with pull-ups on the columns; a closed switch shorts its
// column to the row line, so a matrix key only pulls its column low while that row is driven
module kpsc_keypad_model
(
  // row lines from the scanner
  input  wire logic [7:0]  row_drive_n,
  // switch states, one bit per key, 1 = held down
  input  wire logic [63:0] key_down,
  input  wire logic [7:0]  sf_down,
  input  wire logic [3:0]  ded_down,
  // column lines back to the scanner
  output logic      [7:0]  col_in_n
);
  // wired column level: pull-up unless some closed path reaches ground
  always_comb
  begin
    for (int c = 0; c < 8; c++)
    begin
      // special and dedicated keys tie the column low with no row involved
      col_in_n[c] = ~(sf_down[c] | ((c < 4) && ded_down[c % 4]));
      for (int r = 0; r < 8; r++)
      begin
        // a released row floats high through the pull-up, so no contact
        if (!row_drive_n[r] && key_down[r * 8 + c])
          col_in_n[c] = 1'b0;
      end
    end
  end
endmodule

// ### tb/tb_keypad_scan_control_and_key_report.sv
`timescale 1ns/1ps
module tb_keypad_scan_control_and_key_report
  import kpsc_pkg::*;
;
  // short counts keep one debounce step at 20 cycles and a pass at 45 cycles;
  // settle must cover the row flop plus the two column sync stages, so 3 at least
  localparam int DEB_CYC = 20;
  localparam int SETTLE  = 4;

  logic        clk;           // 200 MHz clock
  logic        sys_rst;       // synchronous reset
  logic [7:0]  reg_addr;      // register offset
  logic        reg_wr;        // write strobe
  logic        reg_rd;        // read strobe
  logic [7:0]  reg_wdata;     // write data
  logic [7:0]  reg_rdata;     // read data
  logic        kclk_en;       // clock gate from system control
  logic [7:0]  row_drive_n;   // row lines
  logic [7:0]  col_in_n;      // column lines
  logic        key_irq;       // pending key-down interrupt
  logic [63:0] key_down;      // matrix switches
  logic [7:0]  sf_down;       // special-function switches
  logic [3:0]  ded_down;      // dedicated switches
  int          n_errors;      // mismatches seen
  int          check_count;   // comparisons made

  kpsc_top #(.DEB_STEP_CYC(DEB_CYC), .ROW_SETTLE_CYC(SETTLE)) DUT (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .keypad_clock_enable(kclk_en), .row_enable(8'hFF), .col_enable(8'hFF),
    .col_in_n(col_in_n), .row_drive_n(row_drive_n), .key_irq(key_irq));

  kpsc_keypad_model pad (
    .row_drive_n(row_drive_n), .key_down(key_down), .sf_down(sf_down),
    .ded_down(ded_down), .col_in_n(col_in_n));

  // free-running clock
  always #2.5 clk = ~clk;

  // one comparison, counted; four-state equality so unknowns never match
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle read strobe; data is taken once the registered answer stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    #1 d = reg_rdata;
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read and compare
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  // re-read a live byte until it shows the value, then compare
  task automatic poll(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    for (int i = 0; i < 300 && d !== exp; i++)
      rd(a, d);
    chk(d, exp);
  endtask

  // bounded wait for the interrupt level, then compare
  task automatic wirq(input logic lvl);
    for (int i = 0; i < 3000 && key_irq !== lvl; i++)
      @(posedge clk);
    #1 chk({7'h00, key_irq}, {7'h00, lvl});
  endtask

  // read a whole report set; the third byte releases the held set
  task automatic rset(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    rc(KPSC_REPORT0_ADDR, b0);
    rc(KPSC_REPORT1_ADDR, b1);
    rc(KPSC_REPORT2_ADDR, b2);
  endtask

  // verdict and end of run
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // hang guard, well beyond the expected few thousand cycles
  initial
  begin
    #100000;
    n_errors++;
    end_sim();
  end

  // main sequence
  initial
  begin
    clk = 0; sys_rst = 1; reg_addr = 0; reg_wr = 0; reg_rd = 0; reg_wdata = 0;
    kclk_en = 1; key_down = 0; sf_down = 0; ded_down = 0;
    n_errors = 0; check_count = 0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    // reset values and an unmapped offset
    rc(KPSC_CTRL_LOW_ADDR, 8'h00);
    rc(KPSC_CTRL_HIGH_ADDR, 8'h00);
    rset(8'hF8, 8'hF8, 8'hF8);
    rc(KPSC_SF_ADDR, 8'hFF);
    rc(KPSC_DED_ADDR, 8'h0F);
    rc(8'h70, 8'h00);
    // read-only report byte ignores a write
    wr(KPSC_REPORT0_ADDR, 8'h00);
    rc(KPSC_REPORT0_ADDR, 8'hF8);
    // count and debounce are set before the scan bit goes up
    wr(KPSC_CTRL_HIGH_ADDR, 8'h20);
    wr(KPSC_CTRL_LOW_ADDR, 8'h04);
    wr(KPSC_CTRL_LOW_ADDR, 8'h05);
    rc(KPSC_CTRL_LOW_ADDR, 8'h05);
    rc(KPSC_CTRL_HIGH_ADDR, 8'h20);
    // row 2 gets its turn once scanning runs
    for (int i = 0; i < 300 && row_drive_n !== 8'hFB; i++)
      @(posedge clk);
    #1 chk(row_drive_n, 8'hFB);
    // press row 2 column 1: 2 ms debounce plus 2 passes must pass first
    @(posedge clk);
    key_down[2 * 8 + 1] <= 1'b1;
    repeat (50) @(posedge clk);
    #1 chk({7'h00, key_irq}, 8'h00);
    wirq(1'b1);
    rc(KPSC_REPORT0_ADDR, 8'h11);
    rc(KPSC_REPORT1_ADDR, 8'hF8);
    repeat (2) @(posedge clk);
    #1 chk({7'h00, key_irq}, 8'h01);
    rc(KPSC_REPORT2_ADDR, 8'hF8);
    repeat (3) @(posedge clk);
    #1 chk({7'h00, key_irq}, 8'h00);
    // release gives an up-only set that raises no interrupt
    @(posedge clk);
    key_down <= 64'h0;
    poll(KPSC_REPORT0_ADDR, 8'h91);
    chk({7'h00, key_irq}, 8'h00);
    rset(8'h91, 8'hF8, 8'hF8);
    // three keys at once, reported lowest row and column first
    @(posedge clk);
    key_down <= (64'h1 << 0) | (64'h1 << (3 * 8 + 5)) | (64'h1 << (7 * 8 + 7));
    wirq(1'b1);
    rset(8'h00, 8'h1D, 8'h3F);
    @(posedge clk);
    key_down <= 64'h0;
    poll(KPSC_REPORT0_ADDR, 8'h80);
    rset(8'h80, 8'h9D, 8'hBF);
    // column 0 as a dedicated key, and a special-function key on column 5
    wr(KPSC_CTRL_HIGH_ADDR, 8'h21);
    rc(KPSC_CTRL_HIGH_ADDR, 8'h21);
    @(posedge clk);
    ded_down <= 4'h1;
    poll(KPSC_DED_ADDR, 8'h0E);
    @(posedge clk);
    ded_down <= 4'h0;
    poll(KPSC_DED_ADDR, 8'h0F);
    @(posedge clk);
    sf_down <= 8'h20;
    poll(KPSC_SF_ADDR, 8'hDF);
    @(posedge clk);
    sf_down <= 8'h00;
    poll(KPSC_SF_ADDR, 8'hFF);
    // scan bit low: rows rest and a press goes unseen
    wr(KPSC_CTRL_LOW_ADDR, 8'h04);
    repeat (60) @(posedge clk);
    #1 chk(row_drive_n, 8'hFF);
    @(posedge clk);
    key_down[4 * 8 + 4] <= 1'b1;
    repeat (300) @(posedge clk);
    #1 chk({7'h00, key_irq}, 8'h00);
    // scan again: the held key is now reported
    wr(KPSC_CTRL_LOW_ADDR, 8'h05);
    wirq(1'b1);
    rset(8'h24, 8'hF8, 8'hF8);
    // clock gate off rests the rows even with the scan bit up
    @(posedge clk);
    kclk_en <= 1'b0;
    repeat (60) @(posedge clk);
    #1 chk(row_drive_n, 8'hFF);
    @(posedge clk);
    kclk_en <= 1'b1;
    end_sim();
  end
endmodule
